/* inc/pic_pkg.sv */
// pic_pkg: constants shared by the prioritised interrupt controller.
// assumes one clock (pclk, one instruction cycle per edge) and an APB master.
package pic_pkg;
   localparam int NUM_SRC    = 16;                 // user interrupt sources
   localparam int NUM_EXT    = 3;                  // external edge pins, sources 0..2
   localparam int PRIO_W     = 3;                  // per-source priority width
   localparam int VEC_W      = 7;                  // latched vector number width
   localparam int LVL_W      = 4;                  // latched new level width
   localparam int VEC_BASE   = 8;                  // user vectors follow the trap vectors
   // register byte addresses
   localparam logic [7:0] ADDR_FLAG  = 8'h00;      // request_flag_regs
   localparam logic [7:0] ADDR_EN    = 8'h04;      // source_enable_regs
   localparam logic [7:0] ADDR_PRIO0 = 8'h08;      // source_priority_regs, sources 0..7
   localparam logic [7:0] ADDR_PRIO1 = 8'h0C;      // source_priority_regs, sources 8..15
   localparam logic [7:0] ADDR_CTL1  = 8'h10;      // global_control_one
   localparam logic [7:0] ADDR_CTL2  = 8'h14;      // global_control_two
   localparam logic [7:0] ADDR_STAT  = 8'h18;      // cpu_status_reg (priority field only)
   localparam logic [7:0] ADDR_CORE  = 8'h1C;      // core_control_reg (extension bit)
   localparam logic [7:0] ADDR_VEC   = 8'h20;      // vector_status_reg
   // field positions
   localparam int NEST_DIS_BIT = 15;               // nesting_disable in control one
   localparam int IPL_LSB      = 5;                // cpu_priority_field at bits 7:5
   localparam int PRIORITY_EXTENSION_BIT_BIT     = 3;                // priority_extension_bit
   localparam int VEC_LVL_LSB  = 8;                // latched_new_level at 11:8
   localparam int PRIO_STRIDE  = 4;                // one nibble per source priority
   // reset and special values
   localparam logic [PRIO_W-1:0] IPL_RESET = 3'h0;
   localparam logic [PRIO_W-1:0] IPL_MAX   = 3'h7;
   // sequence lengths
   localparam int SEQ_CYCLES = 4;                  // entry four cycles, five with extra_stall; return four cycles
   typedef enum logic [1:0] {
      SEQ_C1,
      SEQ_C2,
      SEQ_C3,
      SEQ_C4
   } pic_step_type;
endpackage

/* src/pic_ctrl.sv */
// pic_ctrl: prioritised interrupt controller with four-cycle return and four-cycle entry, five with extra_stall.
// assumes pclk is the instruction clock; ext pins asynchronous; core strobes synchronous.
`timescale 1ns/1ns
module pic_ctrl
   import pic_pkg::*;
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [pic_pkg::NUM_SRC-1:0] periph_event,    // one-cycle source pulses
   input  wire logic [pic_pkg::NUM_EXT-1:0] ext_request_pin, // asynchronous pins
   input  wire logic                        instr_done,      // instruction boundary
   input  wire logic                        extra_stall,     // one-cycle latency add
   input  wire logic                        return_from_isr, // return instruction starts
   input  wire logic                        cpu_asleep,      // sleep or idle
   input  wire logic [23:0]                 cpu_pc,          // pc to push
   input  wire logic [7:0]                  cpu_status_in,   // status byte to push
   input  wire logic [23:0]                 pop_pc,          // pc popped by core
   input  wire logic [7:0]                  pop_status,      // status byte popped
   input  wire logic                        pop_ext,         // extension popped
   output logic                             irq_present,     // request above level
   output logic                             wake_req,        // wake signal
   output logic                             entry_active,    // entry sequence running
   output logic      [1:0]                  entry_step,      // entry cycle index
   output logic                             push_valid,      // context words valid
   output logic      [23:0]                 push_pc,
   output logic      [7:0]                  push_status,
   output logic                             push_ext,
   output logic                             vector_fetch,    // vector table read cycle
   output logic      [6:0]                  vector_addr,     // vector number fetched
   output logic                             return_active,   // return sequence running
   output logic                             resume,          // execution resumes
   output logic      [23:0]                 resume_pc,
   output logic      [7:0]                  resume_status
);
   import pic_pkg::*;

   localparam int NS = NUM_SRC;

   // register state
   logic [NS-1:0]        flag_r;           // request flags
   logic [NS-1:0]        en_r;             // source enables
   logic [PRIO_W-1:0]    prio_r [NS];      // per-source priorities
   logic                 nest_dis_r;       // nesting disable
   logic [NUM_EXT-1:0]   pol_r;            // edge polarities, 1 = falling
   logic [PRIO_W-1:0]    ipl_r;            // cpu priority field
   logic                 priority_extension_bit_r;           // extension bit
   logic [VEC_W-1:0]     vec_r;            // latched vector number
   logic [LVL_W-1:0]     lvl_r;            // latched new level
   // pin synchronisers, first stage read only by second
   logic [NUM_EXT-1:0]   sync1_r, sync2_r, pin_prev_r;
   // sequencer state
   pic_step_type         step_r;
   logic                 ent_r, ret_r, wait_r, stall_r;
   logic [PRIO_W-1:0]    win_prio_r;
   logic [23:0]          save_pc_r;
   logic [7:0]           save_st_r;
   logic                 save_ext_r;
   logic [23:0]          rpc_r;
   logic [7:0]           rst_r;
   logic                 rext_r;

   // apb decode, always ready, zero wait
   wire wr_acc = psel && penable && pwrite;
   wire rd_acc = psel && penable && !pwrite;
   wire hit_flag = (paddr == ADDR_FLAG);
   wire hit_en   = (paddr == ADDR_EN);
   wire hit_p0   = (paddr == ADDR_PRIO0);
   wire hit_p1   = (paddr == ADDR_PRIO1);
   wire hit_c1   = (paddr == ADDR_CTL1);
   wire hit_c2   = (paddr == ADDR_CTL2);
   wire hit_st   = (paddr == ADDR_STAT);
   wire hit_core = (paddr == ADDR_CORE);
   wire hit_vec  = (paddr == ADDR_VEC);
   wire mapped   = hit_flag | hit_en | hit_p0 | hit_p1 | hit_c1 | hit_c2
                 | hit_st | hit_core | hit_vec;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // edge detect on synchronised pins
   wire [NUM_EXT-1:0] rise = sync2_r & ~pin_prev_r;
   wire [NUM_EXT-1:0] fall = ~sync2_r & pin_prev_r;
   wire [NUM_EXT-1:0] ext_evt = (pol_r & fall) | (~pol_r & rise);

   // hardware set events, external pins occupy sources 0..2
   wire [NS-1:0] set_evt = periph_event | {{(NS-NUM_EXT){1'b0}}, ext_evt};

   // pending and wake terms per source
   wire [NS-1:0] pend = flag_r & en_r;
   wire  [NS-1:0] live;
   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_src
         assign live[g] = pend[g] && (prio_r[g] != 3'h0);
      end
   endgenerate
   assign wake_req = cpu_asleep && (|live);

   // winner: highest priority, lowest index on tie
   logic [PRIO_W-1:0] best_p;
   logic [VEC_W-1:0]  best_i;
   always_comb begin
      best_p = 3'h0;
      best_i = 7'h00;
      for (int i = NS - 1; i >= 0; i--) begin
         if (live[i] && (prio_r[i] >= best_p)) begin
            best_p = prio_r[i];
            best_i = VEC_W'(i);
         end
      end
   end

   // present only above the cpu level and with extension clear
   wire busy = ent_r || ret_r;
   assign irq_present = (|live) && !priority_extension_bit_r && (best_p > ipl_r);
   // nesting disabled with level 7 already masks all: priorities only pick ties
   wire take = irq_present && !busy && (instr_done || cpu_asleep);

   // read mux
   logic [31:0] prio_word0, prio_word1;
   always_comb begin
      prio_word0 = 32'h0000_0000;
      prio_word1 = 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
         prio_word0[i*PRIO_STRIDE +: PRIO_W] = prio_r[i];
         prio_word1[i*PRIO_STRIDE +: PRIO_W] = prio_r[i+8];
      end
   end
   wire [31:0] rd_mux =
        hit_flag ? {16'h0000, flag_r}
      : hit_en   ? {16'h0000, en_r}
      : hit_p0   ? prio_word0
      : hit_p1   ? prio_word1
      : hit_c1   ? {16'h0000, nest_dis_r, 15'h0000}
      : hit_c2   ? {29'h0000_0000, pol_r}
      : hit_st   ? {24'h00_0000, ipl_r, 5'h00}
      : hit_core ? {28'h000_0000, priority_extension_bit_r, 3'h0}
      : hit_vec  ? {20'h0_0000, lvl_r, 1'b0, vec_r}
      : 32'h0000_0000;

   // read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;                  // captured at setup, valid in access phase
      end
   end

   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r    <= 3'h0;
         sync2_r    <= 3'h0;
         pin_prev_r <= 3'h0;
      end else begin
         sync1_r    <= ext_request_pin;
         sync2_r    <= sync1_r;
         pin_prev_r <= sync2_r;
      end
   end

   // request flags: hardware set wins over software clear
   wire [NS-1:0] flag_wr = (wr_acc && hit_flag) ? pwdata[NS-1:0] : flag_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_wr | set_evt;
      end
   end

   // enables, polarity, nesting control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r       <= '0;
         pol_r      <= 3'h0;
         nest_dis_r <= 1'b0;
      end else begin
         if (wr_acc && hit_en) en_r <= pwdata[NS-1:0];
         if (wr_acc && hit_c2) pol_r <= pwdata[NUM_EXT-1:0];
         if (wr_acc && hit_c1) nest_dis_r <= pwdata[NEST_DIS_BIT];
      end
   end

   // priorities, one nibble per source
   generate
      for (g = 0; g < NS; g++) begin : g_prio
         wire hit_me = (g < 8) ? hit_p0 : hit_p1;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prio_r[g] <= 3'h0;
            end else if (wr_acc && hit_me) begin
               prio_r[g] <= pwdata[(g%8)*PRIO_STRIDE +: PRIO_W];
            end
         end
      end
   endgenerate

   // cpu level: entry load after save, return restore, software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ipl_r  <= IPL_RESET;
         priority_extension_bit_r <= 1'b0;
      end else if (ent_r && step_r == SEQ_C2) begin
         ipl_r  <= nest_dis_r ? IPL_MAX : win_prio_r;
      end else if (ret_r && step_r == SEQ_C2) begin
         ipl_r  <= rst_r[7:IPL_LSB];
         priority_extension_bit_r <= rext_r;
      end else if (wr_acc && hit_st && !nest_dis_r) begin
         ipl_r  <= pwdata[IPL_LSB +: PRIO_W];
      end
   end

   // vector status latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_r <= 7'h00;
         lvl_r <= 4'h0;
      end else if (take) begin
         vec_r <= VEC_W'(best_i + 7'(VEC_BASE));
         lvl_r <= {1'b0, best_p};
      end
   end

   // sequencer: entry c1..c4, optional stall before c2; return c1..c4
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_r     <= SEQ_C1;
         ent_r      <= 1'b0;
         ret_r      <= 1'b0;
         wait_r     <= 1'b0;
         stall_r    <= 1'b0;
         win_prio_r <= 3'h0;
         save_pc_r  <= 24'h00_0000;
         save_st_r  <= 8'h00;
         save_ext_r <= 1'b0;
         rpc_r      <= 24'h00_0000;
         rst_r      <= 8'h00;
         rext_r     <= 1'b0;
      end else if (take) begin
         ent_r      <= 1'b1;
         step_r     <= SEQ_C1;
         stall_r    <= extra_stall;
         win_prio_r <= best_p;
      end else if (return_from_isr && !busy) begin
         ret_r  <= 1'b1;
         step_r <= SEQ_C1;
      end else if (ent_r) begin
         if (step_r == SEQ_C1 && stall_r) begin
            stall_r <= 1'b0;
         end else begin
            if (step_r == SEQ_C1) begin
               save_pc_r  <= cpu_pc;
               save_st_r  <= cpu_status_in;
               save_ext_r <= priority_extension_bit_r;
            end
            if (step_r == SEQ_C4) ent_r <= 1'b0;
            step_r <= pic_step_type'(step_r + 2'h1);
         end
      end else if (ret_r) begin
         if (step_r == SEQ_C1) begin
            rpc_r  <= pop_pc;
            rst_r  <= pop_status;
            rext_r <= pop_ext;
         end
         if (step_r == SEQ_C4) ret_r <= 1'b0;
         step_r <= pic_step_type'(step_r + 2'h1);
      end
   end

   // core-facing outputs
   assign entry_active  = ent_r;
   assign entry_step    = step_r;
   assign push_valid    = ent_r && step_r == SEQ_C2;
   assign push_pc       = save_pc_r;
   assign push_status   = save_st_r;
   assign push_ext      = save_ext_r;
   assign vector_fetch  = ent_r && step_r == SEQ_C3;
   assign vector_addr   = vec_r;
   assign return_active = ret_r;
   assign resume        = ret_r && step_r == SEQ_C4;
   assign resume_pc     = rpc_r;
   assign resume_status = rst_r;

   // assertions
   a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      set_evt[3] |=> flag_r[3]) else $error("set event lost");
   a_entry_four: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !extra_stall) |=> entry_active [*4] ##1 !entry_active)
      else $error("entry not four cycles");
   a_level_zero_wake: assert property (@(posedge pclk) disable iff (!presetn)
      (live == '0) |-> !wake_req) else $error("wake without live source");
   a_present_above: assert property (@(posedge pclk) disable iff (!presetn)
      irq_present |-> (best_p > ipl_r && !priority_extension_bit_r))
      else $error("present at or below level");
   a_nest_max: assert property (@(posedge pclk) disable iff (!presetn)
      (push_valid && nest_dis_r) |=> ipl_r == IPL_MAX)
      else $error("no force to level 7");
   a_ipl_lock: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_st && nest_dis_r && !busy) |=> $stable(ipl_r))
      else $error("locked level written");
   a_vec_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      push_valid |=> vector_fetch ##1 !vector_fetch)
      else $error("vector fetch misplaced");
   a_return_resume: assert property (@(posedge pclk) disable iff (!presetn)
      (return_from_isr && !busy && !take) |=> ##3 resume)
      else $error("resume not on fourth cycle");
   a_pol_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (ext_evt[0] && !pol_r[0]) |-> sync2_r[0]) else $error("bad edge");
   c_entry: cover property (@(posedge pclk) disable iff (!presetn) take);
   c_return: cover property (@(posedge pclk) disable iff (!presetn) resume);
   c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_req);
endmodule

/* testbench/pic_core_model.sv */
// pic_core_model: behavioural stand-in for the processor core facing the controller.
// assumes one clock shared with the controller; the stack lives here, not in the block.
`timescale 1ns/1ns
module pic_core_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        push_valid,
   input  wire logic [23:0] push_pc,
   input  wire logic [7:0]  push_status,
   input  wire logic        push_ext,
   input  wire logic        return_active,
   output logic             instr_done,
   output logic      [23:0] cpu_pc,
   output logic      [23:0] pop_pc,
   output logic      [7:0]  pop_status,
   output logic             pop_ext
);
   logic [32:0] stack_r [0:7];   // software stack words {ext, status, pc}
   logic [2:0]  sp_r;            // next free slot
   logic        ret_d_r;         // return_active one cycle late
   // fixed pc keeps the expected pushed value simple
   assign cpu_pc = 24'h000200;
   // top of stack is always offered; the block picks it up in return cycle 1
   assign {pop_ext, pop_status, pop_pc} = stack_r[sp_r - 3'h1];
   // instr_done toggles: every instruction takes two cycles, the awkward case
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_done <= 1'b0;
         sp_r       <= 3'h0;
         ret_d_r    <= 1'b0;
         for (int k = 0; k < 8; k++) stack_r[k] <= 33'h1FFFFFFFF;   // junk, never zeros
      end else begin
         instr_done <= ~instr_done;
         ret_d_r    <= return_active;
         // push in entry cycle 2, pop only once the return sequence has ended
         if (push_valid) begin
            stack_r[sp_r] <= {push_ext, push_status, push_pc};
            sp_r          <= sp_r + 3'h1;
         end else if (ret_d_r && !return_active) begin
            sp_r <= sp_r - 3'h1;
         end
      end
   end
endmodule

/* testbench/pic_ctrl_tb.sv */
// pic_ctrl_tb: self-checking bench driving APB, source pulses and pins.
// assumes pic_pkg, pic_ctrl and pic_core_model are compiled before it.
`timescale 1ns/1ns
module pic_ctrl_tb;
   import pic_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, instr_done, pop_ext, irq_present, wake_req, entry_active;
   logic [15:0] periph_event = 16'h0;
   logic [2:0]  ext_request_pin = 3'h0, lvl = 3'h0;   // lvl: expected cpu level
   logic        extra_stall = 1'b0, return_from_isr = 1'b0, cpu_asleep = 1'b0;
   logic [23:0] cpu_pc, pop_pc, push_pc, resume_pc;
   logic [7:0]  cpu_status_in, pop_status, push_status, resume_status;
   logic        push_valid, push_ext, vector_fetch, return_active, resume;
   logic [1:0]  entry_step;
   logic [6:0]  vector_addr;
   logic [31:0] q;
   logic        e;
   int          errors = 0, checks_done = 0, cycles = 0;
   // status byte offered to the block carries the level it should save
   assign cpu_status_in = {lvl, 5'h0A};
   always #25 pclk = ~pclk;
   pic_ctrl i_pic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_event(periph_event), .ext_request_pin(ext_request_pin),
      .instr_done(instr_done), .extra_stall(extra_stall), .return_from_isr(return_from_isr),
      .cpu_asleep(cpu_asleep), .cpu_pc(cpu_pc), .cpu_status_in(cpu_status_in),
      .pop_pc(pop_pc), .pop_status(pop_status), .pop_ext(pop_ext),
      .irq_present(irq_present), .wake_req(wake_req), .entry_active(entry_active),
      .entry_step(entry_step), .push_valid(push_valid), .push_pc(push_pc),
      .push_status(push_status), .push_ext(push_ext), .vector_fetch(vector_fetch),
      .vector_addr(vector_addr), .return_active(return_active), .resume(resume),
      .resume_pc(resume_pc), .resume_status(resume_status));
   pic_core_model i_pic_core_model (.pclk(pclk), .presetn(presetn), .push_valid(push_valid),
      .push_pc(push_pc), .push_status(push_status), .push_ext(push_ext),
      .return_active(return_active), .instr_done(instr_done), .cpu_pc(cpu_pc),
      .pop_pc(pop_pc), .pop_status(pop_status), .pop_ext(pop_ext));
   // verdict and end of run, also reached by the timeout
   task automatic close_out();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // one APB transfer, then an idle cycle so no signal is assigned twice at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is tied high, so this wait ends at the first access-phase edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   // pulse sources for one cycle; the flag is set at the edge that samples it
   task automatic pulse(input logic [15:0] m);
      periph_event <= m;
      @(posedge pclk);
      periph_event <= 16'h0;
   endtask
   // measure how many cycles the entry sequence stands
   task automatic ent(input int len);
      int n, f;
      n = 0;
      f = 0;
      @(negedge pclk);
      while (entry_active !== 1'b1 && n < 30) begin
         @(negedge pclk);
         n++;
      end
      n = 0;
      while (entry_active === 1'b1) begin
         n++;
         if (vector_fetch === 1'b1) begin
            f++;
            chk(entry_step, 2'h2);
         end
         @(negedge pclk);
      end
      chk(n, len);
      chk(f, 1);
      @(posedge pclk);
   endtask
   // return instruction: resume must show in the fourth cycle
   task automatic ret(input logic [7:0] st);
      int n;
      return_from_isr <= 1'b1;
      @(posedge pclk);
      return_from_isr <= 1'b0;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (resume !== 1'b1 && n < 30);
      chk(n, 4);
      chk(resume_pc, 24'h000200);
      chk(resume_status, st);
      @(posedge pclk);
   endtask
   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a <= 32; a += 4) rd(a[7:0], 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      chk(e, 1'b1);
      chk(q, 32'h0);
      // two equal sources at once: lowest index wins
      apb(1'b1, ADDR_PRIO0, 32'h0005_5000);   // sources 3 and 4 at level 5
      apb(1'b1, ADDR_EN, 32'h0000_0038);
      pulse(16'h0018);
      ent(4);
      chk(vector_addr, 7'd11);
      chk(push_ext, 1'b0);
      chk({push_status, push_pc}, {8'h0A, 24'h000200});
      lvl <= 3'h5;
      rd(ADDR_VEC, 32'h0000_050B);
      rd(ADDR_STAT, 32'h0000_00A0);
      apb(1'b1, ADDR_FLAG, 32'h0);
      pulse(16'h0008);
      @(negedge pclk);
      chk(irq_present, 1'b0);
      @(posedge pclk);
      // higher level preempts the running routine
      apb(1'b1, ADDR_PRIO0, 32'h0065_5000);
      pulse(16'h0020);
      ent(4);
      chk(vector_addr, 7'd13);
      lvl <= 3'h6;
      rd(ADDR_STAT, 32'h0000_00C0);
      apb(1'b1, ADDR_FLAG, 32'h0);
      ret(8'hAA);
      lvl <= 3'h5;
      rd(ADDR_STAT, 32'h0000_00A0);
      ret(8'h0A);
      lvl <= 3'h0;
      rd(ADDR_STAT, 32'h0000_0000);
      // nesting disabled: level seven, writes ignored, no preemption
      apb(1'b1, ADDR_CTL1, 32'h0000_8000);
      pulse(16'h0008);
      ent(4);
      rd(ADDR_STAT, 32'h0000_00E0);
      apb(1'b1, ADDR_STAT, 32'h0);
      rd(ADDR_STAT, 32'h0000_00E0);
      pulse(16'h0020);
      @(negedge pclk);
      chk(irq_present, 1'b0);
      @(posedge pclk);
      apb(1'b1, ADDR_FLAG, 32'h0);
      ret(8'h0A);
      apb(1'b1, ADDR_CTL1, 32'h0);
      // wake-up: level zero source stays silent, level one wakes and vectors
      cpu_asleep <= 1'b1;
      apb(1'b1, ADDR_EN, 32'h0000_0040);
      apb(1'b1, ADDR_PRIO0, 32'h0);
      pulse(16'h0040);
      @(negedge pclk);
      chk(wake_req, 1'b0);
      @(posedge pclk);
      apb(1'b1, ADDR_PRIO0, 32'h0100_0000);
      chk(wake_req, 1'b1);
      ent(4);
      chk(vector_addr, 7'd14);
      cpu_asleep <= 1'b0;
      lvl <= 3'h1;
      apb(1'b1, ADDR_FLAG, 32'h0);
      ret(8'h0A);
      lvl <= 3'h0;
      // extra stall lengthens entry by one cycle
      extra_stall <= 1'b1;
      apb(1'b1, ADDR_EN, 32'h0000_0008);
      apb(1'b1, ADDR_PRIO0, 32'h0000_5000);
      pulse(16'h0008);
      ent(5);
      extra_stall <= 1'b0;
      lvl <= 3'h5;
      apb(1'b1, ADDR_FLAG, 32'h0);
      ret(8'h0A);
      lvl <= 3'h0;
      apb(1'b1, ADDR_EN, 32'h0);
      // each pin on falling edge: rise must not set, fall must
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, ADDR_CTL2, 32'h1 << k);
         ext_request_pin[k] <= 1'b1;
         repeat (4) @(posedge pclk);
         rd(ADDR_FLAG, 32'h0);
         ext_request_pin[k] <= 1'b0;
         repeat (4) @(posedge pclk);
         rd(ADDR_FLAG, 32'h1 << k);
         apb(1'b1, ADDR_FLAG, 32'h0);
      end
      // polarity zero: a rising edge on pin 0 must set its flag
      apb(1'b1, ADDR_CTL2, 32'h0);
      ext_request_pin[0] <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(ADDR_FLAG, 32'h1);
      close_out();
   end
endmodule
